// file: verilog/tlviu_regs.svh
// Register offsets, field positions, reset values and source masks of the interrupt unit
`ifndef TLVIU_REGS_SVH
`define TLVIU_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TLVIU_CTRL_OFS      8'h00
`define TLVIU_ENABLE_OFS    8'h04
`define TLVIU_PRIO_OFS      8'h08
`define TLVIU_PEND_OFS      8'h0C
`define TLVIU_RISE_OFS      8'h10
`define TLVIU_FALL_OFS      8'h14
`define TLVIU_STATUS_OFS    8'h18
`define TLVIU_IRQ_STAT_OFS  8'h1C
`define TLVIU_IRQ_MASK_OFS  8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TLVIU_CTRL_GIE_BIT   0
`define TLVIU_CTRL_STOP_BIT  1
`define TLVIU_IRQ_TAKEN_BIT  0
`define TLVIU_IRQ_WAKE_BIT   1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TLVIU_MASK16_RST  16'h0000
`define TLVIU_EDGE_RST    3'h0
`define TLVIU_IRQ_RST     2'h0

// ----------------------------------------------------------------
// Source properties, bit i is query slot i
// ----------------------------------------------------------------
`define TLVIU_AUTO_CLR_MASK  16'h0E0F
`define TLVIU_WAKE_MASK      16'h0E05
`define TLVIU_VEC_BASE       16'h0003
`define TLVIU_VEC_STEP       16'h0008
`define TLVIU_QUERY_GAP_IDX  4'hC
`define TLVIU_EXT0_IDX       0
`define TLVIU_EXT1_IDX       2
`define TLVIU_EXT2_IDX       10

`endif

// file: verilog/tlviu_pkg.sv
// Types of the two-level vectored interrupt unit
package tlviu_pkg;

  typedef struct packed {
    logic        gie;
    logic        stop;
    logic [15:0] en;
    logic [15:0] prio;
    logic [15:0] pend;
    logic [2:0]  rise;
    logic [2:0]  fall;
    logic        ins_hi;
    logic        ins_lo;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        wb_ack;
    logic [31:0] wb_dat;
    logic        int_req;
    logic [15:0] int_vec;
    logic [3:0]  int_src;
    logic        wake;
    logic        irq;
  } tlviu_state_t;

  typedef struct packed {
    logic prev;
    logic primed;
    logic pulse;
  } tlviu_edge_t;

endpackage : tlviu_pkg

// file: verilog/tlviu_edge_det.sv
// Edge detector for one external interrupt pin
`timescale 1ns/1ps
`default_nettype none

module tlviu_edge_det (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Pin and edge selection
  input  wire logic pin,
  input  wire logic rise_en,
  input  wire logic fall_en,
  // Event
  output var  logic pulse
);

  tlviu_pkg::tlviu_edge_t st_q;
  tlviu_pkg::tlviu_edge_t st_d;

  always_comb begin
    st_d        = st_q;
    st_d.prev   = pin;
    st_d.primed = 1'b1;
    // The first sample only seeds the history, so a high pin at reset release is no edge
    st_d.pulse  = st_q.primed & ((rise_en & pin & ~st_q.prev) | (fall_en & ~pin & st_q.prev)); // see (RL3)
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse = st_q.pulse;

endmodule : tlviu_edge_det

`default_nettype wire

// file: verilog/tlviu_top.sv
// Two-level vectored interrupt unit with Wishbone register access
//
// Function
// (RL1) Sixteen request sources: timers, three external pins, converter, PWM, UART, serial, touch.
// (RL2) Each source selects high or low priority; two levels exist.
// (RL3) Each external input triggers on rising, falling or both edges.
// (RL4) Each source has enable, priority bit, pending flag and fixed vector.
// (RL5) Global enable cleared blocks every request regardless of source enables.
// (RL6) External zero: vector 0003H, first in query, auto-clears, wakes from stop.
// (RL7) Timer zero: vector 000BH, query two, auto-clears, no stop wake.
// (RL8) External one: vector 0013H, query three, auto-clears, wakes from stop.
// (RL9) Timer one: vector 001BH, query four, auto-clears, no stop wake.
// (RL10) Serial done: vector 0023H, query five, software clears, no stop wake.
// (RL11) Timer two: vector 002BH, query six, software clears, no stop wake.
// (RL12) Converter done: vector 0033H, query seven, software clears, no stop wake.
// (RL13) High preempts low service; same level never preempts.
// (RL14) Among equal priority requests the smallest query position wins.
// (RL15) Core finishes instruction, pushes PC, loads vector on accept.
// (RL16) Blocked requests stay latched and are taken after return from service.
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tlviu_regs.svh"

module tlviu_top (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // Peripheral events and external pins
  input  wire logic [15:0] periph_evt_i,
  input  wire logic [2:0]  ext_irq_in_i,
  // Core handshake
  output var  logic        int_req_o,
  output var  logic [15:0] int_vector_o,
  output var  logic [3:0]  int_src_o,
  input  wire logic        core_ack_i,
  input  wire logic        core_reti_i,
  // Wake and interrupt
  output var  logic        wake_o,
  output var  logic        irq_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Query numbering skips 12, so slots from the gap on sit one step further
  function automatic logic [15:0] vector_of(input logic [3:0] idx);
    logic [15:0] q;
    q = {12'h000, idx};
    if (idx >= `TLVIU_QUERY_GAP_IDX) begin
      q = q + 16'h0001;
    end
    return `TLVIU_VEC_BASE + q * `TLVIU_VEC_STEP; // see (RL4)
  endfunction : vector_of

  function automatic logic [3:0] first_set(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = i[3:0]; // see (RL14)
      end
    end
    return r;
  endfunction : first_set

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // ----------------------------------------------------------------
  // External edge detection
  // ----------------------------------------------------------------
  // Per-slot copy of the auto-clear set, so it can be indexed by source
  localparam logic [15:0] auto_clr = `TLVIU_AUTO_CLR_MASK;
  // The state is declared here because the pin detectors read its edge selects
  tlviu_pkg::tlviu_state_t st_q;
  tlviu_pkg::tlviu_state_t st_d;
  logic [2:0]  ext_pulse;
  logic [15:0] ext_slot;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ext
      tlviu_edge_det u_edge (
        .clock   (clock),
        .resetn  (resetn),
        .pin     (ext_irq_in_i[g]),
        .rise_en (st_q.rise[g]),
        .fall_en (st_q.fall[g]),
        .pulse   (ext_pulse[g])
      );
    end
  endgenerate

  assign ext_slot = (16'h0001 << `TLVIU_EXT0_IDX) | (16'h0001 << `TLVIU_EXT1_IDX)
                  | (16'h0001 << `TLVIU_EXT2_IDX);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        bus_req;
  logic        bus_wr;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [15:0] evt_all;
  logic [15:0] clr_sw;
  logic [15:0] clr_hw;
  logic [15:0] elig;
  logic [15:0] hi_cand;
  logic [15:0] lo_cand;
  logic [15:0] pick;
  logic        took;
  logic [1:0]  irq_set;
  logic [1:0]  irq_clr;

  assign bus_req = wb_cyc_i & wb_stb_i & ~st_q.wb_ack;
  assign bus_wr  = bus_req & wb_we_i;
  assign wmask   = lane_mask(wb_sel_i);
  assign wval    = wb_dat_i & wmask;

  // All sixteen sources, the external slots fed by the pin detectors
  assign evt_all = (periph_evt_i & ~ext_slot)
                 | (16'(ext_pulse[0]) << `TLVIU_EXT0_IDX)
                 | (16'(ext_pulse[1]) << `TLVIU_EXT1_IDX)
                 | (16'(ext_pulse[2]) << `TLVIU_EXT2_IDX); // see (RL1)

  assign took = core_ack_i & st_q.int_req;

  always_comb begin
    st_d    = st_q;
    clr_sw  = 16'h0000;
    clr_hw  = 16'h0000;
    irq_clr = 2'h0;
    irq_set = 2'h0;

    // ---------------- Register writes ----------------
    if (bus_wr) begin
      case (wb_adr_i)
        `TLVIU_CTRL_OFS: begin
          if (wb_sel_i[0]) begin
            st_d.gie  = wb_dat_i[`TLVIU_CTRL_GIE_BIT];
            st_d.stop = wb_dat_i[`TLVIU_CTRL_STOP_BIT];
          end
        end
        `TLVIU_ENABLE_OFS: begin
          st_d.en = (st_q.en & ~wmask[15:0]) | wval[15:0];
        end
        `TLVIU_PRIO_OFS: begin
          st_d.prio = (st_q.prio & ~wmask[15:0]) | wval[15:0]; // see (RL2)
        end
        `TLVIU_PEND_OFS: begin
          clr_sw = wval[15:0]; // see (RL10) (RL11) (RL12)
        end
        `TLVIU_RISE_OFS: begin
          if (wb_sel_i[0]) begin
            st_d.rise = wb_dat_i[2:0];
          end
        end
        `TLVIU_FALL_OFS: begin
          if (wb_sel_i[0]) begin
            st_d.fall = wb_dat_i[2:0];
          end
        end
        `TLVIU_IRQ_STAT_OFS: begin
          irq_clr = wval[1:0];
        end
        `TLVIU_IRQ_MASK_OFS: begin
          if (wb_sel_i[0]) begin
            st_d.irq_mask = wb_dat_i[1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // ---------------- Service level tracking ----------------
    // Return ends the innermost service, which is the high one when nested
    if (core_reti_i) begin
      if (st_q.ins_hi) begin
        st_d.ins_hi = 1'b0;
      end else begin
        st_d.ins_lo = 1'b0; // see (RL16)
      end
    end
    // The core loads the offered vector after pushing PC; we note the level, clear the taken source's flag if it auto-clears and set the taken status bit
    if (took) begin
      if (st_q.prio[st_q.int_src]) begin
        st_d.ins_hi = 1'b1; // see (RL15)
      end else begin
        st_d.ins_lo = 1'b1;
      end
      clr_hw[st_q.int_src] = auto_clr[st_q.int_src]; // see (RL6) (RL7) (RL8) (RL9)
      irq_set[`TLVIU_IRQ_TAKEN_BIT] = 1'b1;
    end

    // A new event in the clearing cycle keeps its flag set
    st_d.pend = (st_q.pend & ~clr_sw & ~clr_hw) | evt_all; // see (RL4)

    // ---------------- Arbitration on the next state ----------------
    elig    = st_d.pend & st_d.en & {16{st_d.gie}}; // see (RL5)
    hi_cand = elig & st_d.prio;
    lo_cand = elig & ~st_d.prio;
    if (st_d.ins_hi) begin
      pick = 16'h0000; // see (RL13)
    end else if (st_d.ins_lo || (hi_cand != 16'h0000)) begin
      pick = hi_cand;
    end else begin
      pick = lo_cand;
    end
    // Requests not picked stay pending until the service level falls
    st_d.int_req = (pick != 16'h0000); // see (RL16)
    st_d.int_src = first_set(pick);    // see (RL14)
    st_d.int_vec = vector_of(first_set(pick));

    // ---------------- Stop wake ----------------
    st_d.wake = st_d.stop & ((st_d.pend & st_d.en & `TLVIU_WAKE_MASK) != 16'h0000); // see (RL6) (RL8)
    if (st_d.wake && !st_q.wake) begin
      irq_set[`TLVIU_IRQ_WAKE_BIT] = 1'b1;
    end

    // ---------------- Summary interrupt ----------------
    st_d.irq_stat = (st_q.irq_stat & ~irq_clr) | irq_set;
    st_d.irq      = (st_d.irq_stat & st_d.irq_mask) != 2'h0;

    // ---------------- Bus answer ----------------
    st_d.wb_ack = bus_req;
    st_d.wb_dat = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `TLVIU_CTRL_OFS:     st_d.wb_dat = {30'h0, st_q.stop, st_q.gie};
        `TLVIU_ENABLE_OFS:   st_d.wb_dat = {16'h0000, st_q.en};
        `TLVIU_PRIO_OFS:     st_d.wb_dat = {16'h0000, st_q.prio};
        `TLVIU_PEND_OFS:     st_d.wb_dat = {16'h0000, st_q.pend};
        `TLVIU_RISE_OFS:     st_d.wb_dat = {29'h0, st_q.rise};
        `TLVIU_FALL_OFS:     st_d.wb_dat = {29'h0, st_q.fall};
        `TLVIU_STATUS_OFS:   st_d.wb_dat = {st_q.int_vec, 8'h00, st_q.int_src,
                                            st_q.wake, st_q.ins_hi, st_q.ins_lo, st_q.int_req};
        `TLVIU_IRQ_STAT_OFS: st_d.wb_dat = {30'h0, st_q.irq_stat};
        `TLVIU_IRQ_MASK_OFS: st_d.wb_dat = {30'h0, st_q.irq_mask};
        default:             st_d.wb_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_o     = st_q.wb_dat;
  assign wb_ack_o     = st_q.wb_ack;
  assign int_req_o    = st_q.int_req;
  assign int_vector_o = st_q.int_vec;
  assign int_src_o    = st_q.int_src;
  assign wake_o       = st_q.wake;
  assign irq_o        = st_q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  logic [15:0] elig_q;
  assign elig_q = st_q.pend & st_q.en;

  sequence s_take_auto;
    took && auto_clr[st_q.int_src] && !evt_all[st_q.int_src];
  endsequence

  sequence s_take_user;
    took && !auto_clr[st_q.int_src] && !(bus_wr && wb_adr_i == `TLVIU_PEND_OFS);
  endsequence

  property p_gie_gate;
    int_req_o |-> st_q.gie && elig_q[int_src_o];
  endproperty
  a_gie_gate: assert property (p_gie_gate) else $error("request without global enable"); // see (RL5)

  property p_vector;
    int_req_o |-> int_vector_o == vector_of(int_src_o);
  endproperty
  a_vector: assert property (p_vector) else $error("vector does not match source"); // see (RL4)

  property p_no_preempt_hi;
    st_q.ins_hi |-> !int_req_o;
  endproperty
  a_no_preempt_hi: assert property (p_no_preempt_hi) else $error("request during high service"); // see (RL13)

  property p_lo_only_hi;
    (st_q.ins_lo && int_req_o) |-> st_q.prio[int_src_o];
  endproperty
  a_lo_only_hi: assert property (p_lo_only_hi) else $error("same level preemption"); // see (RL13)

  property p_query_order;
    int_req_o |-> ((elig_q & ~(st_q.prio ^ {16{st_q.prio[int_src_o]}})
                   & ((16'h0001 << int_src_o) - 16'h0001)) == 16'h0000);
  endproperty
  a_query_order: assert property (p_query_order) else $error("lower query slot skipped"); // see (RL14)

  property p_auto_clear;
    logic [3:0] s;
    (s_take_auto, s = st_q.int_src) |=> !st_q.pend[s];
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("auto flag not cleared"); // see (RL7)

  property p_user_keep;
    logic [3:0] s;
    (s_take_user, s = st_q.int_src) |=> st_q.pend[s];
  endproperty
  a_user_keep: assert property (p_user_keep) else $error("software flag cleared by hardware"); // see (RL10)

  property p_wake;
    wake_o |-> st_q.stop && ((elig_q & `TLVIU_WAKE_MASK) != 16'h0000);
  endproperty
  a_wake: assert property (p_wake) else $error("wake from non-wake source"); // see (RL6)

  property p_evt_latch;
    (evt_all != 16'h0000) |=> ((st_q.pend & $past(evt_all)) == $past(evt_all));
  endproperty
  a_evt_latch: assert property (p_evt_latch) else $error("event lost in clear cycle"); // see (RL4)

  property p_bus_ack;
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus ack not single cycle");

endmodule : tlviu_top

`default_nettype wire

// file: testbench/tlviu_core_model.sv
// Core model that accepts offered requests and returns from service
`timescale 1ns/1ps
`default_nettype none

module tlviu_core_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Offer from the unit
  input  wire logic        int_req,
  input  wire logic [15:0] int_vec,
  input  wire logic [3:0]  int_src,
  // Bench control
  input  wire logic        take_en,
  input  wire logic [2:0]  ack_wait,
  input  wire logic        reti_go,
  // Handshake and service record
  output var  logic        core_ack,
  output var  logic        core_reti,
  output var  logic [3:0]  taken_src,
  output var  logic [15:0] pc_q,
  output var  logic [1:0]  depth
);
  logic [2:0]  wait_q;
  logic [15:0] stack_q [4];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {core_ack, core_reti, taken_src, pc_q, depth, wait_q} <= '0;
    end else begin
      core_ack  <= 1'b0;
      core_reti <= reti_go;
      wait_q    <= '0;
      if (core_ack && int_req) begin
        stack_q[depth] <= pc_q;
        pc_q           <= int_vec;
        taken_src      <= int_src;
        depth          <= depth + 2'h1;
      end else if (core_reti) begin
        pc_q  <= stack_q[depth - 2'h1];
        depth <= depth - 2'h1;
      end else if (take_en && int_req && !core_ack) begin
        // Slow answers come from waiting ack_wait cycles first
        if (wait_q == ack_wait) begin
          core_ack <= 1'b1;
        end else begin
          wait_q <= wait_q + 3'h1;
        end
      end
    end
  end
endmodule : tlviu_core_model
`default_nettype wire

// file: testbench/tlviu_top_tb.sv
// Self-checking bench of the two-level vectored interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "tlviu_regs.svh"
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; $display("BAD %s exp %0h got %0h", nm, e, a); end end

module tlviu_top_tb;
  logic        clock, resetn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, int_req_o, wake_o, irq_o;
  logic        core_ack_i, core_reti_i, take_en, reti_go;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i, int_src_o, taken_src;
  logic [15:0] periph_evt_i, int_vector_o, pc_q;
  logic [2:0]  ext_irq_in_i, ack_wait;
  logic [1:0]  depth;
  int          err_count = 0;
  int          cmp_count = 0;

  tlviu_top tlviu_top_i (.clock, .resetn, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .periph_evt_i, .ext_irq_in_i, .int_req_o, .int_vector_o, .int_src_o,
    .core_ack_i, .core_reti_i, .wake_o, .irq_o);
  tlviu_core_model tlviu_core_model_i (.clock, .resetn, .int_req(int_req_o), .int_vec(int_vector_o),
    .int_src(int_src_o), .take_en, .ack_wait, .reti_go, .core_ack(core_ack_i), .core_reti(core_reti_i),
    .taken_src, .pc_q, .depth);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic limit(input int n);
    if (n >= 32) begin
      err_count++;
      summarize();
    end
  endtask : limit

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i  <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 32);
    limit(n);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    `CHK(nm, e, q)
  endtask : rd

  task automatic pulse(input logic [15:0] b);
    periph_evt_i <= b;
    @(posedge clock);
    periph_evt_i <= 16'h0;
    repeat (2) @(posedge clock);
  endtask : pulse

  task automatic pins(input logic [2:0] v);
    ext_irq_in_i <= v;
    repeat (4) @(posedge clock);
  endtask : pins

  task automatic take(input logic [3:0] s, input logic [15:0] v);
    logic [1:0] d0;
    int         n;
    d0 = depth;
    n  = 0;
    take_en <= 1'b1;
    while (depth === d0 && n < 32) begin
      @(posedge clock);
      n++;
    end
    take_en <= 1'b0;
    limit(n);
    `CHK("src", s, taken_src)
    `CHK("vector", v, pc_q)
    @(posedge clock);
  endtask : take

  task automatic reti;
    reti_go <= 1'b1;
    @(posedge clock);
    reti_go <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : reti

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_reset;
    rd(`TLVIU_CTRL_OFS, 32'h0, "ctrl");
    rd(`TLVIU_ENABLE_OFS, 32'h0, "enable");
    rd(`TLVIU_PRIO_OFS, 32'h0, "prio");
    // Only the upper enable byte is selected, so the lower one must stay clear
    wb_sel_i <= 4'h2;
    wr(`TLVIU_ENABLE_OFS, 32'hFFFF);
    wb_sel_i <= 4'hF;
    rd(`TLVIU_ENABLE_OFS, 32'hFF00, "enable");
    wr(8'h24, 32'hFFFF_FFFF);
    rd(8'h24, 32'h0, "unmapped");
  endtask : s_reset

  task automatic s_order;
    logic [3:0]  sl [5] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6};
    logic [15:0] vc [5] = '{16'h000B, 16'h001B, 16'h0023, 16'h002B, 16'h0033};
    logic [15:0] p;
    p = 16'h007A;
    wr(`TLVIU_ENABLE_OFS, 32'hFFFF);
    wr(`TLVIU_CTRL_OFS, 32'h1);
    pulse(p);
    rd(`TLVIU_PEND_OFS, {16'h0, p}, "pend");
    for (int i = 0; i < 5; i++) begin
      ack_wait <= 3'(i);
      take(sl[i], vc[i]);
      // Only timer zero and timer one clear themselves on acceptance
      if (i < 2) p[sl[i]] = 1'b0;
      rd(`TLVIU_PEND_OFS, {16'h0, p}, "pend");
      wr(`TLVIU_PEND_OFS, 32'h1 << sl[i]);
      p[sl[i]] = 1'b0;
      reti();
    end
    `CHK("req", 1'b0, int_req_o)
  endtask : s_order

  task automatic s_pins;
    wr(`TLVIU_RISE_OFS, 32'h5);
    wr(`TLVIU_FALL_OFS, 32'h6);
    pins(3'h3);
    rd(`TLVIU_PEND_OFS, 32'h0001, "pend");
    pins(3'h0);
    rd(`TLVIU_PEND_OFS, 32'h0005, "pend");
    take(4'h0, 16'h0003);
    rd(`TLVIU_PEND_OFS, 32'h0004, "pend");
    reti();
    take(4'h2, 16'h0013);
    rd(`TLVIU_PEND_OFS, 32'h0000, "pend");
    reti();
    pins(3'h4);
    rd(`TLVIU_PEND_OFS, 32'h0400, "pend");
    wr(`TLVIU_PEND_OFS, 32'hFFFF);
    pins(3'h0);
    rd(`TLVIU_PEND_OFS, 32'h0400, "pend");
    wr(`TLVIU_PEND_OFS, 32'hFFFF);
  endtask : s_pins

  task automatic s_gie;
    wr(`TLVIU_CTRL_OFS, 32'h0);
    pulse(16'h0002);
    `CHK("req", 1'b0, int_req_o)
    wr(`TLVIU_CTRL_OFS, 32'h1);
    // Offered request: vector, source and request bit, no service running
    rd(`TLVIU_STATUS_OFS, 32'h000B_0011, "status");
    take(4'h1, 16'h000B);
    `CHK("irq", 1'b0, irq_o)
    reti();
  endtask : s_gie

  task automatic s_nest;
    wr(`TLVIU_PRIO_OFS, 32'h000A);
    pulse(16'h0040);
    take(4'h6, 16'h0033);
    pulse(16'h0020);
    `CHK("req", 1'b0, int_req_o)
    pulse(16'h0002);
    take(4'h1, 16'h000B);
    pulse(16'h0008);
    `CHK("req", 1'b0, int_req_o)
    reti();
    take(4'h3, 16'h001B);
    reti();
    `CHK("req", 1'b0, int_req_o)
    wr(`TLVIU_PEND_OFS, 32'h0040);
    reti();
    take(4'h5, 16'h002B);
    wr(`TLVIU_PEND_OFS, 32'h0020);
    reti();
    `CHK("req", 1'b0, int_req_o)
    wr(`TLVIU_PRIO_OFS, 32'h0);
  endtask : s_nest

  task automatic s_wake;
    wr(`TLVIU_CTRL_OFS, 32'h2);
    pulse(16'h0002);
    `CHK("wake", 1'b0, wake_o)
    wr(`TLVIU_PEND_OFS, 32'hFFFF);
    pins(3'h1);
    `CHK("wake", 1'b1, wake_o)
    wr(`TLVIU_PEND_OFS, 32'hFFFF);
    pins(3'h3);
    `CHK("wake", 1'b0, wake_o)
    pins(3'h1);
    `CHK("wake", 1'b1, wake_o)
    wr(`TLVIU_PEND_OFS, 32'hFFFF);
    pins(3'h0);
    // Earlier accepts and wake rises left both status bits set
    rd(`TLVIU_IRQ_STAT_OFS, 32'h3, "irq_stat");
    wr(`TLVIU_IRQ_STAT_OFS, 32'h3);
    wr(`TLVIU_IRQ_MASK_OFS, 32'h1);
    `CHK("irq", 1'b0, irq_o)
    wr(`TLVIU_CTRL_OFS, 32'h1);
    pulse(16'h0002);
    take(4'h1, 16'h000B);
    `CHK("irq", 1'b1, irq_o)
    wr(`TLVIU_IRQ_STAT_OFS, 32'h1);
    `CHK("irq", 1'b0, irq_o)
    reti();
  endtask : s_wake

  initial begin
    {resetn, wb_we_i, wb_cyc_i, wb_stb_i, take_en, reti_go} = '0;
    wb_adr_i     = 8'h00;
    wb_dat_i     = 32'h0;
    wb_sel_i     = 4'hF;
    periph_evt_i = 16'h0;
    ext_irq_in_i = 3'h0;
    ack_wait     = 3'h0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    s_reset();
    s_order();
    s_pins();
    s_gie();
    s_nest();
    s_wake();
    summarize();
  end
endmodule : tlviu_top_tb
`default_nettype wire
